// ===== inc/acas_params.svh
// Constants for the per-axis command acknowledge and status block
//
// Summary of operation
// RQ1: Ack bits 0-2 confirm move and speed
// RQ2: Ack bit 5 confirms interrupt feeding
// RQ3: Ack bit 6 confirms mask/latch enable
// RQ4: Ack bit 7 confirms position preset
// RQ5: Ack bits 8-10 confirm synchronous feeding
// RQ6: Ack bit 11 confirms origin latch enable
// RQ7: Ack bit 14 confirms origin latch clear
// RQ8: Ack bit 15 confirms latch flag clear
// RQ9: Program leaves reserved ack bits alone
// RQ10: Busy bit 0 high during axis operation
// RQ11: Unassigned axes busy during memory operation
// RQ12: Bit 1 high when jogging may start
// RQ13: Bit 2 high when direct operation may start
// RQ14: Bit 4 on stop command or input
// RQ15: Stop flag blocks other start acknowledges
// RQ16: Bit 5 follows synchronous group stop
// RQ17: Bit 6 follows all-unit synchronous stop
// RQ18: Bit 7 confirms high-speed start
// RQ19: Bit 8 flags failed start conditions
// RQ20: Start error or priority loss also flags
// RQ21: Ack stays while command high, then falls
// RQ22: Reserved status bits read zero
`ifndef ACAS_PARAMS_SVH
`define ACAS_PARAMS_SVH

// ***********************************************************
// Register indices (byte address is four times the index)
// ***********************************************************
`define ACAS_IDX_CMD      12'h000
`define ACAS_IDX_ACK      12'h001
`define ACAS_IDX_STAT     12'h002

// ***********************************************************
// Field masks and positions
// ***********************************************************
`define ACAS_ACK_VALID    16'hCFE7
`define ACAS_START_MASK   16'h0727
`define ACAS_STAT_VALID   16'h01F7
`define ACAS_ST_BUSY      0
`define ACAS_ST_JOG       1
`define ACAS_ST_DIRECT    2
`define ACAS_ST_STOP      4
`define ACAS_ST_GRP       5
`define ACAS_ST_ALL       6
`define ACAS_ST_HSPTP     7
`define ACAS_ST_INVALID   8

// ***********************************************************
// Reset values
// ***********************************************************
`define ACAS_RST_WORD     16'h0000
`define ACAS_RST_DATA     32'h0000_0000

`endif

// ===== inc/acas_pkg.sv
// Types shared by the command acknowledge and status block
package acas_pkg;

  // Axis engine conditions seen by the status word
  typedef struct packed {
    logic axis_busy;      // Axis performing an operation
    logic mem_op;         // Memory operation running
    logic unassigned;     // Axis absent from axis configuration
    logic jog_ok;         // Jogging may start
    logic direct_ok;      // Direct operation may start
    logic imm_stop_cmd;   // Immediate stop command accepted
    logic dec_stop_cmd;   // Deceleration stop command accepted
    logic estop_in;       // Emergency stop input active
    logic decel_in;       // Deceleration input active
    logic grp_stop_bit;   // Synchronous group stop bit
    logic all_stop_bit;   // All-unit synchronous stop bit
    logic sys_stopped;    // System has come to rest
    logic hsptp_req;      // High-speed point-to-point start
    logic start_fail;     // Start conditions not met
    logic start_err;      // Error arose at command start
    logic prio_lost;      // Competing command had priority
  } acas_axis_in_t;

  // State of the acknowledge bank
  typedef struct packed {
    logic [15:0] ack;     // Acknowledge flags
    logic [15:0] accept;  // Bits accepted in the last cycle
  } acas_ack_st_t;

  // State of the top level
  typedef struct packed {
    logic [15:0] cmd;     // Command word from software
    logic [15:0] stat;    // Command status word
    logic        grp_seen;  // Group stop accepted
    logic        all_seen;  // All-unit stop accepted
    logic [31:0] prdata;  // Read data
    logic        pready;  // Transfer completion
    logic        pslverr; // Transfer error
  } acas_top_st_t;

endpackage

// ===== hdl/acas_ack_bank.sv
// Acknowledge flag bank with four-phase handshake per bit
`timescale 1ns/1ns
`include "acas_params.svh"
module acas_ack_bank #(
  parameter logic [15:0] VALID = `ACAS_ACK_VALID
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [15:0]  cmd,
  input  wire logic [15:0]  block,
  output      logic [15:0]  ack,
  output      logic [15:0]  accept
);
  import acas_pkg::*;

  acas_ack_st_t st_r;   // All state
  acas_ack_st_t st_nxt; // Next state

  // ***********************************************************
  // Handshake
  // ***********************************************************
  // Accept new command bits unless blocked, hold while high
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // Held flag stays; a new one needs an unblocked command
      st_nxt.ack = cmd & VALID & (st_r.ack | ~block); // RQ21 RQ15
      st_nxt.accept = st_nxt.ack & ~st_r.ack;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ack    = st_r.ack;
  assign accept = st_r.accept;

  // ***********************************************************
  // Checks
  // ***********************************************************
  AST_ACK_FALL: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
    ce && !cmd[0] |=> !ack[0])
    else $error("ack bit 0 held after command cleared");
  AST_ACK_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RQ21
    ce && ack[1] && cmd[1] |=> ack[1])
    else $error("ack bit 1 dropped while command high");

endmodule

// ===== hdl/acas_top.sv
// APB register bank for per-axis command acknowledge and status
`timescale 1ns/1ns
`include "acas_params.svh"
module acas_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output      logic [31:0]           prdata,
  output      logic                  pready,
  output      logic                  pslverr,
  input  wire acas_pkg::acas_axis_in_t axis_in,
  output      logic [15:0]           ack_word,
  output      logic [15:0]           status_word
);
  import acas_pkg::*;

  acas_top_st_t  st_r;    // All state
  acas_top_st_t  st_nxt;  // Next state
  logic [15:0]   ack;     // Acknowledge flags
  logic [15:0]   accept;  // Newly accepted bits
  logic [15:0]   block;   // Blocked command bits
  logic [11:0]   idx;     // Register index of the access
  logic          setup;   // Setup phase of a transfer
  logic          wr_done; // Write takes effect now
  logic          start_acc; // A start command was accepted
  logic          inv_set; // Start-invalid event

  // ***********************************************************
  // Helpers
  // ***********************************************************
  // Map a word index to its byte address
  function automatic logic [11:0] byte_addr(input logic [11:0] i);
    byte_addr = {i[9:0], 2'b00};
  endfunction

  // Check that an address is one of ours
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == byte_addr(`ACAS_IDX_CMD))
             || (a == byte_addr(`ACAS_IDX_ACK))
             || (a == byte_addr(`ACAS_IDX_STAT));
  endfunction

  // ***********************************************************
  // Acknowledge bank
  // ***********************************************************
  // Start bits are held off while the stop flag stands
  assign block = st_r.stat[`ACAS_ST_STOP] ? `ACAS_START_MASK
                                           : 16'h0000; // RQ15

  // Bits 0-2, 5-11, 14, 15 each answer their command bit
  acas_ack_bank #(
    .VALID (`ACAS_ACK_VALID)  // RQ1 RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ8
  ) u_ack (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .cmd     (st_r.cmd),
    .block   (block),
    .ack     (ack),
    .accept  (accept)
  );

  // ***********************************************************
  // Bus decode
  // ***********************************************************
  assign idx      = {2'b00, paddr[11:2]};
  assign setup    = psel && !penable && !st_r.pready;
  assign wr_done  = psel && penable && st_r.pready && pwrite
                 && !st_r.pslverr;
  assign start_acc = |(accept & `ACAS_START_MASK);
  assign inv_set  = axis_in.start_fail             // RQ19
                 || axis_in.start_err || axis_in.prio_lost; // RQ20

  // ***********************************************************
  // Next state
  // ***********************************************************
  // Bus answer, command register and status word
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // Bus: answer one cycle after setup, then release
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (setup) begin
        st_nxt.pready = 1'b1;
        st_nxt.prdata = `ACAS_RST_DATA;
        if (!is_mapped(paddr)) begin
          // Unmapped address
          st_nxt.pslverr = 1'b1;
        end else if (pwrite) begin
          // Only the command word takes writes
          st_nxt.pslverr = (idx != `ACAS_IDX_CMD);
        end else begin
          case (idx)
            `ACAS_IDX_CMD:  st_nxt.prdata = {16'h0000, st_r.cmd};
            `ACAS_IDX_ACK:  st_nxt.prdata = {16'h0000, ack};
            `ACAS_IDX_STAT: st_nxt.prdata = {16'h0000, st_r.stat};
            default:        st_nxt.prdata = `ACAS_RST_DATA;
          endcase
        end
      end
      // Command write with byte lanes
      if (wr_done) begin
        if (pstrb[0]) begin
          st_nxt.cmd[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
          st_nxt.cmd[15:8] = pwdata[15:8];
        end
      end
      // Busy, including unassigned axes in memory operation
      st_nxt.stat[`ACAS_ST_BUSY] = axis_in.axis_busy // RQ10
        || (axis_in.mem_op && axis_in.unassigned);   // RQ11
      // Start permissions
      st_nxt.stat[`ACAS_ST_JOG]    = axis_in.jog_ok;    // RQ12
      st_nxt.stat[`ACAS_ST_DIRECT] = axis_in.direct_ok; // RQ13
      // Stop input flag
      st_nxt.stat[`ACAS_ST_STOP] = axis_in.imm_stop_cmd // RQ14
        || axis_in.dec_stop_cmd || axis_in.estop_in
        || axis_in.decel_in;
      // Remember stop bits while the system stays stopped
      st_nxt.grp_seen = axis_in.grp_stop_bit
        || (st_r.grp_seen && axis_in.sys_stopped);
      st_nxt.all_seen = axis_in.all_stop_bit
        || (st_r.all_seen && axis_in.sys_stopped);
      st_nxt.stat[`ACAS_ST_GRP] = axis_in.grp_stop_bit // RQ16
        || (st_r.grp_seen && axis_in.sys_stopped);
      st_nxt.stat[`ACAS_ST_ALL] = axis_in.all_stop_bit // RQ17
        || (st_r.all_seen && axis_in.sys_stopped);
      // High-speed start acknowledge
      st_nxt.stat[`ACAS_ST_HSPTP] = axis_in.hsptp_req; // RQ18
      // Start invalid: new start clears, failure sets and wins
      if (start_acc) begin
        st_nxt.stat[`ACAS_ST_INVALID] = 1'b0;
      end
      if (inv_set) begin
        st_nxt.stat[`ACAS_ST_INVALID] = 1'b1; // RQ19 RQ20
      end
      // Reserved bits forced low
      st_nxt.stat = st_nxt.stat & `ACAS_STAT_VALID; // RQ22
    end
  end

  // ***********************************************************
  // State register
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata      = st_r.prdata;
  assign pready      = st_r.pready;
  assign pslverr     = st_r.pslverr;
  assign ack_word    = ack;
  assign status_word = st_r.stat;

  // ***********************************************************
  // Checks
  // ***********************************************************
  AST_ACK_ABS: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    ce && st_r.cmd[0] && !ack[0] && !st_r.stat[`ACAS_ST_STOP]
    |=> ack[0])
    else $error("absolute move not acknowledged");

  AST_ACK_FEED: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    ce && st_r.cmd[5] && !st_r.stat[`ACAS_ST_STOP] |=> ack[5])
    else $error("interrupt feeding not acknowledged");

  AST_ACK_MASK: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    ce && st_r.cmd[6] |=> ack[6])
    else $error("latch enable not acknowledged");

  AST_ACK_PRESET: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    ce && st_r.cmd[7] |=> ack[7])
    else $error("preset not acknowledged");

  AST_ACK_SYNC: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    ce && st_r.cmd[10] && !st_r.stat[`ACAS_ST_STOP] |=> ack[10])
    else $error("sync torque not acknowledged");

  AST_ACK_ORIGIN: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    ce && st_r.cmd[11] |=> ack[11])
    else $error("origin latch enable not acknowledged");

  AST_ACK_OCLR: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    ce && st_r.cmd[14] |=> ack[14])
    else $error("origin latch clear not acknowledged");

  AST_ACK_LCLR: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    ce && st_r.cmd[15] |=> ack[15])
    else $error("latch clear not acknowledged");

  AST_BUSY: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    ce && axis_in.axis_busy |=> status_word[`ACAS_ST_BUSY])
    else $error("busy missing during operation");

  AST_BUSY_MEM: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    ce && axis_in.mem_op && axis_in.unassigned
    |=> status_word[`ACAS_ST_BUSY])
    else $error("unassigned axis not busy");

  AST_JOG: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    ce |=> status_word[`ACAS_ST_JOG] == $past(axis_in.jog_ok))
    else $error("jog enable wrong");

  AST_DIRECT: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    ce |=> status_word[`ACAS_ST_DIRECT] == $past(axis_in.direct_ok))
    else $error("direct enable wrong");

  AST_STOP: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    ce && (axis_in.estop_in || axis_in.imm_stop_cmd)
    |=> status_word[`ACAS_ST_STOP])
    else $error("stop flag missing");

  AST_STOP_BLOCK: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    ce && st_r.stat[`ACAS_ST_STOP] && !ack[1] |=> !ack[1])
    else $error("start acknowledged during stop");

  AST_GRP: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
    ce && axis_in.grp_stop_bit ##1 ce && axis_in.sys_stopped
    |=> status_word[`ACAS_ST_GRP])
    else $error("group stop flag lost");

  AST_ALL: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
    ce && axis_in.all_stop_bit |=> status_word[`ACAS_ST_ALL])
    else $error("all-unit stop flag missing");

  AST_HSPTP: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
    ce && axis_in.hsptp_req |=> status_word[`ACAS_ST_HSPTP])
    else $error("high-speed start not acknowledged");

  AST_INVALID: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
    ce && axis_in.start_fail |=> status_word[`ACAS_ST_INVALID])
    else $error("start invalid not set");

  AST_INV_PRIO: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
    ce && (axis_in.prio_lost || axis_in.start_err)
    |=> status_word[`ACAS_ST_INVALID])
    else $error("start invalid missed error or priority");

  AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn) // RQ22
    (status_word & ~`ACAS_STAT_VALID) == 16'h0000
    && (ack_word & ~`ACAS_ACK_VALID) == 16'h0000)
    else $error("reserved bit set");

  AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && !penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");

endmodule

// ===== tb/test_axis_command_ack_status.sv
// Self-checking bench for the command acknowledge and status block
`timescale 1ns/1ns
`include "acas_params.svh"
module test_axis_command_ack_status;
  import acas_pkg::*;

  // ***********************************************************
  // Signals and constants
  // ***********************************************************
  logic                  pclk;        // Bus clock
  logic                  presetn;     // Async reset, active low
  logic                  ce;          // Clock enable
  logic                  psel;        // Bus select
  logic                  penable;     // Bus access phase
  logic                  pwrite;      // Bus direction
  logic [11:0]           paddr;       // Bus byte address
  logic [31:0]           pwdata;      // Bus write data
  logic [3:0]            pstrb;       // Write byte strobes
  logic [31:0]           prdata;      // Bus read data
  logic                  pready;      // Bus completion
  logic                  pslverr;     // Bus error
  acas_axis_in_t         axis_in;     // Axis engine levels
  logic [15:0]           ack_word;    // Acknowledge flags
  logic [15:0]           status_word; // Command status
  int                    n_errors;    // Mismatch count
  int                    n_compared;  // Comparison count
  logic [31:0]           rd;          // Last read data
  logic                  er;          // Last error response
  logic [15:0]           e16;         // Expected word
  localparam logic [11:0] A_CMD  = `ACAS_IDX_CMD << 2;  // Command word
  localparam logic [11:0] A_ACK  = `ACAS_IDX_ACK << 2;  // Ack word
  localparam logic [11:0] A_STAT = `ACAS_IDX_STAT << 2; // Status word
  localparam logic [15:0] START  = 16'h0727;            // Start bits
  // Axis input patterns and the status each one must give
  localparam logic [15:0] S_IN [15] = '{16'h8000, 16'h4000, 16'h6000,
    16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100,
    16'h0080, 16'h0040, 16'h0020, 16'h0008, 16'h0010, 16'h0000};
  localparam logic [15:0] S_EX [15] = '{16'h0001, 16'h0000, 16'h0001,
    16'h0000, 16'h0002, 16'h0004, 16'h0010, 16'h0010, 16'h0010,
    16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0000, 16'h0000};

  acas_top DUT (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .pstrb       (pstrb),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .axis_in     (axis_in),
    .ack_word    (ack_word),
    .status_word (status_word)
  );

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  // ***********************************************************
  // Tasks
  // ***********************************************************
  // Print the counts and the verdict, then stop
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compare one value against its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Let n edges pass, then step clear of the edge
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // One bus transfer: setup, then access until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drive the axis engine levels just after an edge
  task automatic drive_axis(input logic [15:0] v);
    @(posedge pclk);
    axis_in <= v;
  endtask

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; pstrb = 4'h0; axis_in = '0;
    n_errors = 0; n_compared = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    tick(2);
    // Idle words and bus responses
    chk({16'h0000, ack_word}, 32'h0000_0000);
    chk({16'h0000, status_word}, 32'h0000_0000);
    apb(1'b0, A_STAT, 32'h0, 4'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b1, A_ACK, 32'h0000_FFFF, 4'hF);
    chk({31'h0, er}, 32'h0000_0001);
    // Walk every command bit through a full handshake
    for (int i = 0; i < 16; i++) begin
      e16 = 16'h0001 << i;
      apb(1'b1, A_CMD, {16'h0000, e16}, 4'h3);
      tick(2);
      chk(ack_word, e16 & 16'hCFE7);
      apb(1'b0, A_ACK, 32'h0, 4'h0);
      chk(rd, {16'h0000, e16 & 16'hCFE7});
      apb(1'b1, A_CMD, 32'h0000_0000, 4'h3);
      tick(2);
      chk(ack_word, 16'h0000);
    end
    // Only the low lane lands when one strobe is set
    apb(1'b1, A_CMD, 32'h0000_FFFF, 4'h1);
    tick(2);
    chk(ack_word, 16'h00E7);
    apb(1'b1, A_CMD, 32'h0000_0000, 4'h3);
    tick(2);
    // Only the high lane lands with the other strobe
    apb(1'b1, A_CMD, 32'h0000_FFFF, 4'h2);
    tick(2);
    chk(ack_word, 16'hCF00);
    apb(1'b1, A_CMD, 32'h0000_0000, 4'h3);
    tick(2);
    // Axis inputs one by one plus one pair, no start-invalid cause, and their status bits
    for (int i = 0; i < 15; i++) begin
      drive_axis(S_IN[i]);
      tick(2);
      chk(status_word, S_EX[i]);
      apb(1'b0, A_STAT, 32'h0, 4'h0);
      chk(rd, {16'h0000, S_EX[i]});
    end
    // Synchronous stop flags held on while the system rests
    for (int k = 0; k < 2; k++) begin
      e16 = (k == 0) ? 16'h0020 : 16'h0040;
      drive_axis((k == 0) ? 16'h0050 : 16'h0030);
      tick(2);
      chk(status_word, e16);
      drive_axis(16'h0010);
      tick(2);
      chk(status_word, e16);
      drive_axis(16'h0000);
      tick(2);
      chk(status_word, 16'h0000);
    end
    // Clock enable low freezes the status word
    @(posedge pclk);
    ce <= 1'b0;
    drive_axis(16'h8000);
    tick(2);
    chk(status_word, 16'h0000);
    @(posedge pclk);
    ce <= 1'b1;
    tick(2);
    chk(status_word, 16'h0001);
    drive_axis(16'h0000);
    tick(2);
    // Stop input blocks start bits but not the others
    drive_axis(16'h0100);
    tick(2);
    apb(1'b1, A_CMD, 32'h0000_FFFF, 4'h3);
    tick(3);
    chk(ack_word, 16'hCFE7 & ~START);
    drive_axis(16'h0000);
    tick(4);
    chk(ack_word, 16'hCFE7);
    apb(1'b1, A_CMD, 32'h0000_0000, 4'h3);
    tick(2);
    chk(ack_word, 16'h0000);
    // Start-invalid from each cause, cleared by a fresh start
    for (int k = 0; k < 3; k++) begin
      drive_axis(16'h0004 >> k);
      drive_axis(16'h0000);
      tick(3);
      chk(status_word, 16'h0100);
      apb(1'b1, A_CMD, 32'h0000_0001, 4'h3);
      tick(3);
      chk(status_word, 16'h0000);
      apb(1'b1, A_CMD, 32'h0000_0000, 4'h3);
      tick(2);
    end
    finish_test();
  end
endmodule
